//--- lech_defines.svh
// register offsets, field positions and reset values for the lane error counter block
`ifndef LECH_DEFINES_SVH
`define LECH_DEFINES_SVH
`define LECH_ADDR_W          12
`define LECH_LINK_PAGE_ADDR  12'h300
`define LECH_SOFT_RST_ADDR   12'h475
`define LECH_SOFT_RST_BIT    3
`define LECH_CTRL1_ADDR      12'h461
`define LECH_CTRL2_ADDR      12'h462
`define LECH_HOLD1_ADDR      12'h489
`define LECH_HOLD2_ADDR      12'h48a
`define LECH_CNT_BASE_ADDR   12'h4a0
`define LECH_IRQ_STAT_ADDR   12'h4b0
`define LECH_IRQ_CLR_ADDR    12'h4b1
`define LECH_IRQ_EN_ADDR     12'h4b2
`define LECH_HOLD_RST        3'h7
`define LECH_ENA_RST         3'h7
`define LECH_ENA_LSB         3
`define LECH_TERM_COUNT      8'hff
`define LECH_PAGES           2
`endif

//--- lech_pkg.sv
// types shared by the lane error counter block
package lech_pkg;
  typedef logic [2:0] lech_err_vec_t;  // bit2 ctrl char, bit1 not in table, bit0 disparity
  typedef logic [7:0] lech_count_t;
endpackage

//--- lech_lane_error_counter_hold.sv
// lane error counters with terminal count hold, paged by link, for lanes 1 and 2
// Notes on behaviour
// - with a counter's hold bit set, the counter stops at 0xff and stays there.
// - a held counter keeps 0xff until its own reset bit clears it to zero.
// - with a counter's hold bit clear, the counter wraps from 0xff to zero and keeps going.
// - the link page control picks which link's hold, control and counter registers an access reaches; soft reset and interrupt registers are shared.
// - in each three-bit field, bit 2 is control char, bit 1 not in table, bit 0 disparity.
// - each lane has three enable bits in the same order; only enabled counters count.
// - each lane has three reset bits in the same order; each clears its counter.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`include "lech_defines.svh"
module lech_lane_error_counter_hold #(
  parameter int PAGES = `LECH_PAGES,
  parameter int LANES = 2
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  // register port
  input  wire logic [11:0]            reg_addr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_write,
  input  wire logic                   reg_read,
  output      logic [7:0]             reg_rdata,
  // error events per link and lane (same clock)
  input  wire lech_pkg::lech_err_vec_t lane1_err [PAGES],
  input  wire lech_pkg::lech_err_vec_t lane2_err [PAGES],
  // decoder soft reset and interrupt
  output      logic                   lane_deserializer_decoder_soft_reset,
  output      logic                   irq
);
  import lech_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  localparam int NCNT = LANES * 3;
  logic                 page_reg,  page_next;
  logic                 qrst_reg,  qrst_next;
  lech_err_vec_t        hold_reg   [PAGES][LANES];
  lech_err_vec_t        hold_next  [PAGES][LANES];
  lech_err_vec_t        ena_reg    [PAGES][LANES];
  lech_err_vec_t        ena_next   [PAGES][LANES];
  lech_count_t          cnt_reg    [PAGES][NCNT];
  lech_count_t          cnt_next   [PAGES][NCNT];
  logic [NCNT-1:0]      stat_reg,  stat_next;
  logic [NCNT-1:0]      irq_en_reg, irq_en_next;
  logic [7:0]           rdata_reg, rdata_next;
  lech_err_vec_t        err_in     [PAGES][LANES];

  // decode a lane control address to its lane index, or -1
  function automatic int lane_of(input logic [11:0] a, input logic [11:0] b1,
                                 input logic [11:0] b2);
    if (a == b1) return 0;
    if (a == b2) return 1;
    return -1;
  endfunction

  always_comb begin
    for (int p = 0; p < PAGES; p++) begin
      err_in[p][0] = lane1_err[p];
      err_in[p][1] = lane2_err[p];
    end
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    int          hl;
    int          cl;
    int          ci;
    int          ln;
    int          bt;
    logic        wr_ctrl;
    logic [NCNT-1:0] set_ev;
    set_ev = '0;
    hl = lane_of(reg_addr, `LECH_HOLD1_ADDR, `LECH_HOLD2_ADDR);
    cl = lane_of(reg_addr, `LECH_CTRL1_ADDR, `LECH_CTRL2_ADDR);
    ci = -1;
    ln = 0;
    bt = 0;
    wr_ctrl = 1'b0;
    page_next = page_reg;
    qrst_next = qrst_reg;
    hold_next = hold_reg;
    ena_next  = ena_reg;
    irq_en_next = irq_en_reg;
    stat_next = stat_reg;
    if (reg_addr >= `LECH_CNT_BASE_ADDR &&
        reg_addr < `LECH_CNT_BASE_ADDR + 12'(NCNT))
      ci = int'(reg_addr - `LECH_CNT_BASE_ADDR);
    if (reg_write) begin
      if (reg_addr == `LECH_LINK_PAGE_ADDR)
        page_next = reg_wdata[0];
      if (reg_addr == `LECH_SOFT_RST_ADDR)
        qrst_next = reg_wdata[`LECH_SOFT_RST_BIT];
      if (hl >= 0 && qrst_reg)
        hold_next[page_reg][hl] = reg_wdata[2:0];
      if (cl >= 0) begin
        ena_next[page_reg][cl] = reg_wdata[5:`LECH_ENA_LSB];
        wr_ctrl = 1'b1;
      end
      if (reg_addr == `LECH_IRQ_EN_ADDR)
        irq_en_next = reg_wdata[NCNT-1:0];
    end
    // counters: reset wins over count
    for (int p = 0; p < PAGES; p++) begin
      for (int c = 0; c < NCNT; c++) begin
        ln = c / 3;
        bt = 2 - (c % 3);  // index 0 = bit2 ctrl char
        cnt_next[p][c] = cnt_reg[p][c];
        // reset bit clears even a held count
        if (wr_ctrl && p == int'(page_reg) && ln == cl && reg_wdata[bt]) begin
          cnt_next[p][c] = '0;
        end else if (ena_reg[p][ln][bt] && err_in[p][ln][bt]) begin
          if (hold_reg[p][ln][bt] && cnt_reg[p][c] == `LECH_TERM_COUNT)
            cnt_next[p][c] = cnt_reg[p][c];  // keeps held value
          else
            cnt_next[p][c] = cnt_reg[p][c] + 8'h01;  // wraps
          if (cnt_reg[p][c] == `LECH_TERM_COUNT) begin
            stat_next[c] = 1'b1;
            set_ev[c] = 1'b1;  // remembered so a clear cannot swallow it
          end
        end
      end
    end
    // write-one clear; a new event in the same cycle wins
    if (reg_write && reg_addr == `LECH_IRQ_CLR_ADDR) begin
      for (int c = 0; c < NCNT; c++) begin
        if (reg_wdata[c] && !set_ev[c])
          stat_next[c] = 1'b0;
      end
    end
    // read data, one cycle later
    rdata_next = 8'h00;
    if (reg_read) begin
      if (reg_addr == `LECH_LINK_PAGE_ADDR)
        rdata_next = {7'h00, page_reg};
      else if (reg_addr == `LECH_SOFT_RST_ADDR)
        rdata_next = 8'(qrst_reg) << `LECH_SOFT_RST_BIT;
      else if (hl >= 0)
        rdata_next = {5'h00, hold_reg[page_reg][hl]};
      else if (cl >= 0)
        rdata_next = {2'h0, ena_reg[page_reg][cl], 3'h0};
      else if (ci >= 0)
        rdata_next = cnt_reg[page_reg][ci];
      else if (reg_addr == `LECH_IRQ_STAT_ADDR)
        rdata_next = 8'(stat_reg);
      else if (reg_addr == `LECH_IRQ_EN_ADDR)
        rdata_next = 8'(irq_en_reg);
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      page_reg   <= 1'b0;
      qrst_reg   <= 1'b0;
      stat_reg   <= '0;
      irq_en_reg <= '0;
      rdata_reg  <= 8'h00;
      for (int p = 0; p < PAGES; p++) begin
        for (int l = 0; l < LANES; l++) begin
          hold_reg[p][l] <= `LECH_HOLD_RST;
          ena_reg[p][l]  <= `LECH_ENA_RST;
        end
        for (int c = 0; c < NCNT; c++)
          cnt_reg[p][c] <= 8'h00;
      end
    end else begin
      page_reg   <= page_next;
      qrst_reg   <= qrst_next;
      stat_reg   <= stat_next;
      irq_en_reg <= irq_en_next;
      rdata_reg  <= rdata_next;
      hold_reg   <= hold_next;
      ena_reg    <= ena_next;
      cnt_reg    <= cnt_next;
    end
  end

  // outputs
  assign reg_rdata = rdata_reg;
  assign lane_deserializer_decoder_soft_reset = qrst_reg;
  assign irq = |(stat_reg & irq_en_reg);
endmodule

//--- lech_chk.sv
// register port assertions for the lane error counter block
`timescale 1ns/1ps
module lech_chk (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // register port and decoder reset
  input wire logic [11:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [7:0]  reg_rdata,
  input wire logic        lane_deserializer_decoder_soft_reset
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire sr = lane_deserializer_decoder_soft_reset;
  wire ws = reg_write && reg_addr == 12'h475;
  // hold write while unlocked, then read back
  sequence hold_set;
    reg_write && reg_addr == 12'h489 && sr ##1 reg_read && reg_addr == 12'h489;
  endsequence
  // page write, then read back
  sequence page_set;
    reg_write && reg_addr == 12'h300 ##1 reg_read && reg_addr == 12'h300;
  endsequence
  idle_rdata_a: assert property (!reg_read |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  page_readback_a: assert property (page_set |=> reg_rdata[0] == $past(reg_wdata[0], 2))
    else $error("page select lost");
  hold_readback_a: assert property (hold_set |=> reg_rdata[2:0] == $past(reg_wdata[2:0], 2))
    else $error("hold field lost");
  hold_reserved_a: assert property (reg_read && reg_addr == 12'h489 |=> reg_rdata[7:3] == 5'h00)
    else $error("hold reserved bits set");
  rst_bits_zero_a: assert property (reg_read && reg_addr == 12'h461 |=> reg_rdata[2:0] == 3'h0)
    else $error("reset bits read back");
  unmapped_zero_a: assert property (reg_read && reg_addr == 12'h123 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  soft_rst_set_a: assert property (ws |=> sr == $past(reg_wdata[3]))
    else $error("soft reset not taken");
  soft_rst_keep_a: assert property (!ws |=> $stable(sr))
    else $error("soft reset moved");
endmodule
bind lech_lane_error_counter_hold lech_chk u_lech_chk (.clk, .reset_n, .reg_addr, .reg_wdata,
  .reg_write, .reg_read, .reg_rdata, .lane_deserializer_decoder_soft_reset);

//--- lech_err_src.sv
// far end error source steering error pulses onto one link page
`timescale 1ns/1ps
module lech_err_src (
  // page steering and error patterns
  input  wire logic [0:0]              pg,
  input  wire logic [2:0]              p1,
  input  wire logic [2:0]              p2,
  // error pulses toward the receiver
  output      lech_pkg::lech_err_vec_t lane1_err [2],
  output      lech_pkg::lech_err_vec_t lane2_err [2]
);
  import lech_pkg::*;
  // only the selected link sees errors
  assign lane1_err[0] = pg ? 3'h0 : p1;
  assign lane1_err[1] = pg ? p1 : 3'h0;
  assign lane2_err[0] = pg ? 3'h0 : p2;
  assign lane2_err[1] = pg ? p2 : 3'h0;
endmodule

//--- tb_top.sv
// self-checking bench for the lane error counter block
`timescale 1ns/1ps
module tb_top;
  import lech_pkg::*;
  logic          clk = 0, reset_n = 0, w = 0, r = 0, sr, irq;
  logic [0:0]    pg = 0;
  logic [11:0]   a = 0;
  logic [7:0]    d = 0, q;
  logic [2:0]    p1 = 0, p2 = 0;
  lech_err_vec_t e1 [2], e2 [2];
  int            n_fail = 0, compares = 0;
  // reset values: address and expected read
  logic [19:0]   rows [7] = '{20'h48907, 20'h48a07, 20'h46138, 20'h30000, 20'h47500,
                              20'h4b000, 20'h12300};
  // free running clock
  initial begin
    forever #2 clk = ~clk;
  end
  lech_lane_error_counter_hold u_lech_lane_error_counter_hold (.clk, .reset_n, .reg_addr(a),
    .reg_wdata(d), .reg_write(w), .reg_read(r), .reg_rdata(q), .lane1_err(e1), .lane2_err(e2),
    .lane_deserializer_decoder_soft_reset(sr), .irq);
  lech_err_src u_lech_err_src (.pg, .p1, .p2, .lane1_err(e1), .lane2_err(e2));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one bus cycle, strobes held until the next call
  task bus(input logic wv, input logic rv, input logic [11:0] ad, input logic [7:0] dt);
    w <= wv;
    r <= rv;
    a <= ad;
    d <= dt;
    @(posedge clk);
  endtask
  task rd(input logic [11:0] ad, input logic [7:0] ex);
    bus(1'b0, 1'b1, ad, 8'h00);
    #1 chk(q, ex);
  endtask
  task idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 12'h000, 8'h00);
  endtask
  task err(input logic [2:0] v1, input logic [2:0] v2, input int n);
    p1 <= v1;
    p2 <= v2;
    idle(n);
    p1 <= 3'h0;
    p2 <= 3'h0;
  endtask
  task test_done;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    foreach (rows[i]) rd(rows[i][19:8], rows[i][7:0]);
    bus(1'b1, 1'b0, 12'h489, 8'h00);
    rd(12'h489, 8'h07);
    bus(1'b1, 1'b0, 12'h475, 8'h08);
    bus(1'b1, 1'b0, 12'h489, 8'h03);
    rd(12'h489, 8'h03);
    err(3'h7, 3'h0, 257);
    rd(12'h4a0, 8'h01);
    rd(12'h4a1, 8'hff);
    rd(12'h4a2, 8'hff);
    bus(1'b1, 1'b0, 12'h461, 8'h3a);
    rd(12'h4a1, 8'h00);
    rd(12'h4a2, 8'hff);
    rd(12'h4b0, 8'h07);
    bus(1'b1, 1'b0, 12'h4b2, 8'h02);
    idle(2);
    #1 chk({7'h00, irq}, 8'h01);
    bus(1'b1, 1'b0, 12'h4b1, 8'h02);
    idle(2);
    #1 chk({7'h00, irq}, 8'h00);
    bus(1'b1, 1'b0, 12'h462, 8'h08);
    err(3'h0, 3'h7, 3);
    rd(12'h4a3, 8'h00);
    rd(12'h4a5, 8'h03);
    bus(1'b1, 1'b0, 12'h300, 8'h01);
    rd(12'h300, 8'h01);
    pg <= 1'b1;
    err(3'h1, 3'h0, 2);
    rd(12'h4a2, 8'h02);
    rd(12'h489, 8'h07);
    test_done;
  end
endmodule
